//--- hw/osd_debouncer.sv
// top of the octal switch debouncer: eight channels, three-state bus, change flag
// assumes switch inputs are asynchronous pins; supply_low comes from an analog monitor
`timescale 1ns/1ps
`include "osd_params.svh"
module osd_debouncer #(
    parameter int CHANNELS   = 8,
    parameter int TICK_DIV   = `OSD_TICK_DIV,
    parameter int QUAL_TICKS = `OSD_QUAL_TICKS
) (
    input  wire logic                clock,
    input  wire logic                rst_b,
    input  wire logic [CHANNELS-1:0] switch_inputs,
    input  wire logic                output_enable_n,
    input  wire logic                supply_low,
    output logic      [CHANNELS-1:0] debounced_outputs,
    output logic      [CHANNELS-1:0] debounced_outputs_oe,
    output logic                     change_flag_n
);
    initial begin
        if (CHANNELS != 8) $error("only eight channels supported");
        if (TICK_DIV < 2 || TICK_DIV > 1048575) $error("TICK_DIV out of range");
    end

    // tick divider: slower schedule keeps the counters narrow
    logic [19:0] div_r;
    logic        tick_r;
    logic [1:0]  en_sync_r;
    logic [1:0]  low_sync_r;
    logic [CHANNELS-1:0] loads;
    logic [CHANNELS-1:0] outs;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= 20'h00000;
            tick_r <= 1'b0;
            en_sync_r <= 2'b11;
            low_sync_r <= 2'b11;
        end else begin
            en_sync_r <= {en_sync_r[0], output_enable_n};
            low_sync_r <= {low_sync_r[0], supply_low};
            tick_r <= (div_r == 20'(TICK_DIV - 1));
            div_r <= (div_r == 20'(TICK_DIV - 1)) ? 20'h00000 : div_r + 20'h00001;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            osd_chan_if cif ();
            assign cif.tick = tick_r;
            assign cif.transparent = low_sync_r[1];
            assign cif.raw = switch_inputs[g];
            assign outs[g] = cif.out;
            assign loads[g] = cif.load;
            osd_chan #(.QUAL_TICKS(QUAL_TICKS)) u_ch (
                .clock (clock),
                .rst_b (rst_b),
                .bus   (cif.chan)
            );
        end
    endgenerate

    // flag and bus drivers, registered one cycle after the channel flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            change_flag_n <= `OSD_CHANGE_RST;
            debounced_outputs <= `OSD_OUT_RST;
            debounced_outputs_oe <= '0;
        end else begin
            debounced_outputs <= outs;
            debounced_outputs_oe <= {CHANNELS{!en_sync_r[1]}};
            if (!en_sync_r[1])
                change_flag_n <= 1'b1;
            else if (|loads)
                change_flag_n <= 1'b0;
        end
    end

    a_flag_on_load: assert property (@(posedge clock) disable iff (!rst_b)
        (|loads && en_sync_r[1]) |=> !change_flag_n)
        else $error("flag missed an update");
    a_flag_high_en: assert property (@(posedge clock) disable iff (!rst_b)
        !en_sync_r[1] |=> change_flag_n)
        else $error("flag low while enabled");
    a_oe_follows_en: assert property (@(posedge clock) disable iff (!rst_b)
        en_sync_r[1] |=> debounced_outputs_oe == '0)
        else $error("outputs driven while disabled");
    a_out_tracks: assert property (@(posedge clock) disable iff (!rst_b)
        ##1 debounced_outputs == $past(outs))
        else $error("bus data not channel state");
    a_tick_period: assert property (@(posedge clock) disable iff (!rst_b)
        tick_r |=> !tick_r)
        else $error("tick too long");
    c_flag_low: cover property (@(posedge clock) disable iff (!rst_b) !change_flag_n);
    c_any_load: cover property (@(posedge clock) disable iff (!rst_b) |loads);
    c_enable_clear: cover property (@(posedge clock) disable iff (!rst_b)
        !change_flag_n ##1 !en_sync_r[1]);
    c_transp_load: cover property (@(posedge clock) disable iff (!rst_b)
        low_sync_r[1] && |loads);
    c_oe_on: cover property (@(posedge clock) disable iff (!rst_b)
        debounced_outputs_oe == '1);

    // tick spacing watch: the first tick after reset has no reference, so it is skipped
    logic [19:0] gap_r;
    logic        seen_tick_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gap_r <= 20'h00000;
            seen_tick_r <= 1'b0;
        end else begin
            gap_r <= tick_r ? 20'h00001 : gap_r + 20'h00001;
            if (tick_r)
                seen_tick_r <= 1'b1;
        end
    end

    a_tick_spacing: assert property (@(posedge clock) disable iff (!rst_b)
        (tick_r && seen_tick_r) |-> gap_r == 20'(TICK_DIV))
        else $error("tick spacing wrong");

    a_div_bound: assert property (@(posedge clock) disable iff (!rst_b)
        div_r < 20'(TICK_DIV))
        else $error("divider out of range");

    // outside transparency a channel may only flip on a tick
    a_change_on_tick: assert property (@(posedge clock) disable iff (!rst_b)
        (outs != $past(outs)) |-> ($past(tick_r) || $past(low_sync_r[1])))
        else $error("channel flipped off tick");

    a_load_marks_change: assert property (@(posedge clock) disable iff (!rst_b)
        loads == (outs ^ $past(outs)))
        else $error("load pulse not matching change");

    a_flag_fall_cause: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(change_flag_n) |-> $past(|loads && en_sync_r[1]))
        else $error("flag fell without update");

    a_flag_rise_cause: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(change_flag_n) |-> !$past(en_sync_r[1]))
        else $error("flag cleared without enable");

    // flag stays low until the host enables the bus
    a_flag_keeps_low: assert property (@(posedge clock) disable iff (!rst_b)
        (!change_flag_n && en_sync_r[1]) |=> !change_flag_n)
        else $error("flag dropped on its own");

    a_oe_on_enable: assert property (@(posedge clock) disable iff (!rst_b)
        !en_sync_r[1] |=> debounced_outputs_oe == '1)
        else $error("outputs not driven while enabled");

    a_oe_uniform: assert property (@(posedge clock) disable iff (!rst_b)
        (debounced_outputs_oe == '0) || (debounced_outputs_oe == '1))
        else $error("output enables disagree");
endmodule : osd_debouncer

//--- inc/osd_params.svh
// constants for the octal switch debouncer: timing counts and reset values
// assumes a single 125 MHz clock; included by bare name
`ifndef OSD_PARAMS_SVH
`define OSD_PARAMS_SVH
`define OSD_CLK_HZ       125000000
`define OSD_DEBOUNCE_MS  40
`define OSD_TICK_HZ      1000
`define OSD_TICK_DIV     (`OSD_CLK_HZ / `OSD_TICK_HZ)
`define OSD_QUAL_TICKS   ((`OSD_DEBOUNCE_MS * `OSD_TICK_HZ) / 1000)
`define OSD_CHANGE_RST   1'b1
`define OSD_OUT_RST      8'h00
`endif

//--- inc/osd_pkg.sv
// types shared by the debouncer modules
package osd_pkg;
    typedef struct packed {
        logic [1:0] sync;
        logic [15:0] cnt;
        logic        out;
    } osd_chan_t;
endpackage : osd_pkg

//--- inc/osd_chan_if.sv
// per-channel carrier between top and channel modules
`timescale 1ns/1ps
interface osd_chan_if;
    logic tick;
    logic transparent;
    logic raw;
    logic out;
    logic load;
    modport top  (output tick, output transparent, output raw, input out, input load);
    modport chan (input tick, input transparent, input raw, output out, output load);
endinterface : osd_chan_if

//--- hw/osd_chan.sv
// one debounce channel: synchroniser, stability counter, output flop
// assumes tick is a one-cycle enable from the shared divider
`timescale 1ns/1ps
`include "osd_params.svh"
module osd_chan #(
    parameter int QUAL_TICKS = `OSD_QUAL_TICKS
) (
    input  wire logic   clock,
    input  wire logic   rst_b,
    osd_chan_if.chan    bus
);
    initial begin
        if (QUAL_TICKS < 1 || QUAL_TICKS > 65535) $error("QUAL_TICKS out of range");
    end

    osd_pkg::osd_chan_t st_r, st_nxt;
    logic               load_nxt;
    logic               load_r;

    always_comb begin
        st_nxt = st_r;
        load_nxt = 1'b0;
        st_nxt.sync = {st_r.sync[0], bus.raw};
        if (bus.transparent) begin
            st_nxt.cnt = 16'h0000;
            load_nxt = (st_r.sync[1] != st_r.out);
            st_nxt.out = st_r.sync[1];
        end else if (st_r.sync[1] != st_r.out) begin
            if (!bus.tick) begin
            end else if (st_r.cnt == 16'(QUAL_TICKS - 1)) begin
                st_nxt.cnt = 16'h0000;
                st_nxt.out = st_r.sync[1];
                load_nxt = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end
        end else begin
            st_nxt.cnt = 16'h0000;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            load_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            load_r <= load_nxt;
        end
    end

    assign bus.out = st_r.out;
    assign bus.load = load_r;

    a_out_holds_stable: assert property (@(posedge clock) disable iff (!rst_b)
        (!bus.transparent && st_r.out != st_nxt.out) |-> bus.tick)
        else $error("output changed without tick");
    a_cnt_cleared_eq: assert property (@(posedge clock) disable iff (!rst_b)
        (!bus.transparent && st_r.sync[1] == st_r.out) |=> st_r.cnt == 16'h0000)
        else $error("counter not cleared");
endmodule : osd_chan

//--- test/osd_sw_model.sv
// partner: eight switch contacts feeding the debouncer
// assumes one clock; a bouncing line toggles every cycle, faster than a tick
`timescale 1ns/1ps
module osd_sw_model (
    input  wire logic       clock,
    input  wire logic [7:0] level,
    input  wire logic [7:0] bounce,
    output logic      [7:0] switch_inputs
);
    initial switch_inputs = 8'h00;
    // a bouncing contact never rests long enough to qualify
    always @(posedge clock) begin
        switch_inputs <= (level & ~bounce) | (~switch_inputs & bounce);
    end
endmodule : osd_sw_model

//--- test/tb.sv
// testbench for the octal debouncer, short tick and count for speed
// assumes osd_sw_model as switches; host bus has pull-ups
`timescale 1ns/1ps
module tb;
    logic       clock = 1'b0;
    logic       rst_b = 1'b0;
    logic [7:0] level = 8'h00;
    logic [7:0] bounce = 8'h00;
    logic       output_enable_n = 1'b1;
    logic       supply_low = 1'b0;
    logic [7:0] switch_inputs;
    logic [7:0] debounced_outputs;
    logic [7:0] debounced_outputs_oe;
    logic       change_flag_n;
    int         error_cnt = 0;
    int         samples_checked = 0;
    // released lines float to the pull-ups
    wire  [7:0] bus_value = (debounced_outputs & debounced_outputs_oe) | ~debounced_outputs_oe;
    osd_sw_model osd_sw_model_inst (.clock(clock), .level(level), .bounce(bounce),
        .switch_inputs(switch_inputs));
    osd_debouncer #(.TICK_DIV(4), .QUAL_TICKS(3)) osd_debouncer_inst (.clock(clock),
        .rst_b(rst_b), .switch_inputs(switch_inputs), .output_enable_n(output_enable_n),
        .supply_low(supply_low), .debounced_outputs(debounced_outputs),
        .debounced_outputs_oe(debounced_outputs_oe), .change_flag_n(change_flag_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : chk
    // sample 1 ns after the edge so design updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic t_bounce;
        @(posedge clock);
        bounce <= 8'hff;
        cyc(20);
        chk(debounced_outputs, 8'h00, "bounce");
        chk(bus_value, 8'hff, "released");
        @(posedge clock);
        bounce <= 8'h00;
        level <= 8'hff;
        cyc(6);
        chk(debounced_outputs, 8'h00, "early");
        chk({7'h00, change_flag_n}, 8'h01, "early flag");
        cyc(20);
        chk(debounced_outputs, 8'hff, "rise");
        chk({7'h00, change_flag_n}, 8'h00, "flag set");
        $display("test bounce done");
    endtask : t_bounce
    task automatic t_read;
        @(posedge clock);
        output_enable_n <= 1'b0;
        cyc(4);
        chk(debounced_outputs_oe, 8'hff, "oe");
        chk(bus_value, 8'hff, "bus");
        chk({7'h00, change_flag_n}, 8'h01, "flag clear");
        @(posedge clock);
        level <= 8'h5a;
        cyc(30);
        chk(bus_value, 8'h5a, "fall");
        chk({7'h00, change_flag_n}, 8'h01, "flag held");
        @(posedge clock);
        output_enable_n <= 1'b1;
        cyc(6);
        chk({7'h00, change_flag_n}, 8'h01, "no pending");
        chk(debounced_outputs_oe, 8'h00, "oe off");
        $display("test read done");
    endtask : t_read
    task automatic t_transp;
        @(posedge clock);
        supply_low <= 1'b1;
        level <= 8'h3c;
        cyc(5);
        chk(debounced_outputs, 8'h3c, "transparent");
        @(posedge clock);
        supply_low <= 1'b0;
        $display("test transparent done");
    endtask : t_transp
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    initial begin
        forever #4 clock = ~clock;
    end
    // whole run is about 105 cycles; this limit of 1500 cycles is about fourteen times that
    initial begin
        #12000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        cyc(4);
        t_bounce();
        t_read();
        t_transp();
        complete_run();
    end
endmodule : tb
